//--- verilog/sar_readout_pkg.sv
package sar_readout_pkg;

    // result and shift path
    localparam int RESULT_WIDTH = 14;
    localparam int CNT_WIDTH    = 16;
    localparam int RD_CNT_WIDTH = 5;

    // clocking and conversion timing
    localparam int CLK_PERIOD_PS = 8000;
    // longest conversion time; plain default, the analog core sets the truth
    localparam int CONV_TIME_NS  = 1600;
    localparam int CONV_CYCLES   =
        (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // falling edges that end a readout with and without the leading bit
    localparam logic [RD_CNT_WIDTH-1:0] READ_END_PLAIN =
        RD_CNT_WIDTH'(RESULT_WIDTH);
    localparam logic [RD_CNT_WIDTH-1:0] READ_END_BUSY  =
        RD_CNT_WIDTH'(RESULT_WIDTH + 1);

    // register port
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 32;
    localparam logic [ADDR_WIDTH-1:0] REG_CONFIG = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] REG_RESULT = 4'h8;
    localparam logic [CNT_WIDTH-1:0]  CONFIG_RESET = CNT_WIDTH'(CONV_CYCLES);

    // status register fields
    localparam int ST_SELECT_BIT  = 0;
    localparam int ST_BUSY_BIT    = 1;
    localparam int ST_CONVERT_BIT = 2;
    localparam int ST_PWRDN_BIT   = 3;
    localparam int ST_DRIVE_BIT   = 4;
    localparam int ST_READING_BIT = 5;

    // pin synchroniser reset level: high keeps a false trigger edge away
    localparam logic [2:0] PIN_RESET = 3'h7;

    typedef enum logic {
        phase_acquire,
        phase_convert
    } phase_t;

endpackage

//--- verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
    import sar_readout_pkg::*;
#(
    parameter int         WIDTH     = 3,
    parameter logic [2:0] RESET_VAL = PIN_RESET
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    always_comb begin
        next_s        = s;
        next_s.meta   = async_in;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s.meta   <= WIDTH'(RESET_VAL);
            s.stable <= WIDTH'(RESET_VAL);
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;

endmodule

//--- verilog/conv_timer.sv
`timescale 1ns/1ps
module conv_timer
    import sar_readout_pkg::*;
#(
    parameter int WIDTH = CNT_WIDTH
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             start_in,
    input  wire logic [WIDTH-1:0] length_in,
    output logic                  active_out,
    output logic                  done_out
);

    typedef struct packed {
        logic             active;
        logic             done;
        logic [WIDTH-1:0] count;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        if (start_in) begin
            next_s.active = 1'b1;
            // a zero length still takes one cycle
            next_s.count  = (length_in == '0) ? WIDTH'(1) : length_in;
        end else if (s.active) begin
            if (s.count == WIDTH'(1)) begin
                next_s.active = 1'b0;
                next_s.done   = 1'b1;
            end
            next_s.count = s.count - WIDTH'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign active_out = s.active;
    assign done_out   = s.done;

endmodule

//--- verilog/sar_adc_serial_readout.sv
// Summary of operation
// - trigger rise latches chain select: high gives select mode, low chain.
// - select mode enables busy if trigger or chain select low at finish.
// - chain mode enables busy only when serial clock high at trigger rise.
// - select mode trigger rise starts conversion and floats the output.
// - 3-wire busy mode keeps output floating until conversion completes.
// - with busy enabled, output goes from floating to driven at finish: low in select mode, high in chain mode.
// - after each conversion the core powers down and acquires.
// - busy modes shift result msb first, one bit per clock falling edge.
// - 3-wire busy readout floats at fifteenth falling edge or trigger rise.
// - chain select and trigger both low drives the output low outside a readout.
// - 4-wire no busy: chain select low shows msb, falls shift later bits.
// - 4-wire no busy floats at fourteenth falling edge or select rise.
// - 4-wire busy floats at fifteenth falling edge or chain select rise.
// - trigger rise with chain select and clock low starts chain mode without busy.
// - chain mode without busy shows the msb once conversion completes.
// - chain mode shifts on clock falls, chain select entering the low end.
`timescale 1ns/1ps
module sar_adc_serial_readout
    import sar_readout_pkg::*;
#(
    parameter int WIDTH = RESULT_WIDTH
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  conversion_trigger_in,
    input  wire logic                  chain_select_input_in,
    input  wire logic                  serial_clock_in,
    input  wire logic [WIDTH-1:0]      result_in,
    input  wire logic [ADDR_WIDTH-1:0] addr_in,
    input  wire logic [DATA_WIDTH-1:0] wr_data_in,
    input  wire logic                  wr_en_in,
    input  wire logic                  rd_en_in,
    output logic      [DATA_WIDTH-1:0] rd_data_out,
    output logic                       serial_result_out,
    output logic                       serial_result_oe_n_out,
    output logic                       power_down_out
);

    typedef struct packed {
        phase_t                  phase;
        logic                    cnv_d;
        logic                    sck_d;
        logic                    select_mode;
        logic                    busy_en;
        logic                    lead;
        logic                    reading;
        logic                    done;
        logic [RD_CNT_WIDTH-1:0] rd_cnt;
        logic [WIDTH-1:0]        shreg;
        logic [WIDTH-1:0]        result;
        logic [CNT_WIDTH-1:0]    conv_cycles;
        logic                    serial_result_output;
        logic                    sdo_oe_n;
        logic                    pwr_dn;
        logic [DATA_WIDTH-1:0]   rd_data;
    } state_t;

    state_t s;
    state_t next_s;

    logic [2:0] pins;
    logic       cnv_s;
    logic       sdi_s;
    logic       sck_s;
    logic       cnv_rise;
    logic       sck_fall;
    logic       selected;
    logic       conv_done;
    logic       conv_active;

    pin_sync #(
        .WIDTH     (3),
        .RESET_VAL (PIN_RESET)
    ) u_pin_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in ({conversion_trigger_in, chain_select_input_in,
                    serial_clock_in}),
        .sync_out (pins)
    );

    assign cnv_s    = pins[2];
    assign sdi_s    = pins[1];
    assign sck_s    = pins[0];
    assign cnv_rise = cnv_s & ~s.cnv_d;
    assign sck_fall = ~sck_s & s.sck_d;
    // a select-mode part talks whenever either line is low
    assign selected = ~(cnv_s & sdi_s);

    conv_timer #(
        .WIDTH (CNT_WIDTH)
    ) u_conv_timer (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .start_in   (cnv_rise),
        .length_in  (s.conv_cycles),
        .active_out (conv_active),
        .done_out   (conv_done)
    );

    function automatic logic [RD_CNT_WIDTH-1:0] read_end(input logic busy);
        read_end = busy ? READ_END_BUSY : READ_END_PLAIN;
    endfunction

    always_comb begin
        next_s       = s;
        next_s.cnv_d = cnv_s;
        next_s.sck_d = sck_s;

        if (wr_en_in && addr_in == REG_CONFIG) begin
            next_s.conv_cycles = wr_data_in[CNT_WIDTH-1:0];
        end

        if (cnv_rise) begin
            next_s.phase       = phase_convert;
            next_s.select_mode = sdi_s;
            next_s.busy_en     = sdi_s ? 1'b0 : sck_s;
            next_s.reading     = 1'b0;
            next_s.done        = 1'b0;
            next_s.lead        = 1'b0;
            next_s.rd_cnt      = '0;
            next_s.pwr_dn      = 1'b0;
        end else if (s.phase == phase_convert) begin
            if (conv_done) begin
                next_s.phase  = phase_acquire;
                next_s.pwr_dn = 1'b1;
                next_s.shreg  = result_in;
                next_s.result = result_in;
                if (s.select_mode) begin
                    next_s.busy_en = selected;
                    next_s.lead    = selected;
                    next_s.reading = selected;
                    // result stays pending until selection or a new trigger
                    next_s.done    = 1'b0;
                end else begin
                    next_s.reading = 1'b1;
                    next_s.lead    = s.busy_en;
                end
            end
        end else if (s.select_mode) begin
            if (!s.reading && !s.done && selected) begin
                next_s.reading = 1'b1;
            end else if (s.reading && !selected) begin
                next_s.reading = 1'b0;
                next_s.done    = 1'b1;
            end else if (s.reading && sck_fall) begin
                if (s.lead) begin
                    next_s.lead = 1'b0;
                end else begin
                    next_s.shreg = {s.shreg[WIDTH-2:0], sdi_s};
                end
                next_s.rd_cnt = s.rd_cnt + RD_CNT_WIDTH'(1);
                if (next_s.rd_cnt == read_end(s.busy_en)) begin
                    next_s.reading = 1'b0;
                    next_s.done    = 1'b1;
                end
            end
        end else if (s.reading) begin
            if (!cnv_s) begin
                // chain readout is over once the trigger drops
                next_s.reading = 1'b0;
                next_s.done    = 1'b1;
            end else if (sck_fall) begin
                if (s.lead) begin
                    next_s.lead = 1'b0;
                end else begin
                    next_s.shreg = {s.shreg[WIDTH-2:0], sdi_s};
                end
            end
        end

        // output follows the next state so the pin is a plain flop
        if (next_s.phase == phase_acquire && next_s.reading) begin
            next_s.sdo_oe_n = 1'b0;
            // select-mode start bit is low, chain start bit is high
            next_s.serial_result_output = next_s.lead ? ~next_s.select_mode
                                     : next_s.shreg[WIDTH-1];
        end else if (!cnv_s && !sdi_s) begin
            next_s.sdo_oe_n = 1'b0;
            next_s.serial_result_output      = 1'b0;
        end else begin
            next_s.sdo_oe_n = 1'b1;
            next_s.serial_result_output      = 1'b0;
        end

        next_s.rd_data = '0;
        if (rd_en_in) begin
            case (addr_in)
                REG_CONFIG: next_s.rd_data = DATA_WIDTH'(s.conv_cycles);
                REG_STATUS: begin
                    next_s.rd_data[ST_SELECT_BIT]  = s.select_mode;
                    next_s.rd_data[ST_BUSY_BIT]    = s.busy_en;
                    next_s.rd_data[ST_CONVERT_BIT] = conv_active;
                    next_s.rd_data[ST_PWRDN_BIT]   = s.pwr_dn;
                    next_s.rd_data[ST_DRIVE_BIT]   = ~s.sdo_oe_n;
                    next_s.rd_data[ST_READING_BIT] = s.reading;
                end
                REG_RESULT: next_s.rd_data = DATA_WIDTH'(s.result);
                default:    next_s.rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s             <= '0;
            s.phase       <= phase_acquire;
            s.cnv_d       <= 1'b1;
            s.sck_d       <= 1'b1;
            s.select_mode <= 1'b1;
            s.done        <= 1'b1;
            s.sdo_oe_n    <= 1'b1;
            s.pwr_dn      <= 1'b1;
            s.conv_cycles <= CONFIG_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data_out            = s.rd_data;
    assign serial_result_out      = s.serial_result_output;
    assign serial_result_oe_n_out = s.sdo_oe_n;
    assign power_down_out         = s.pwr_dn;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_MODE_LATCH: assert property (
        cnv_rise |=> s.select_mode == $past(sdi_s))
        else $error("mode not taken from chain select at trigger rise");

    AST_BUSY_SELECT: assert property (
        conv_done && s.phase == phase_convert && s.select_mode && !cnv_rise
        |=> s.busy_en == $past(selected))
        else $error("select-mode busy enable wrong at completion");

    AST_BUSY_CHAIN: assert property (
        cnv_rise && !sdi_s |=> s.busy_en == $past(sck_s))
        else $error("chain-mode busy enable not from serial clock");

    AST_HIZ_START: assert property (
        cnv_rise && sdi_s |=> serial_result_oe_n_out && !power_down_out)
        else $error("output not floating after select-mode start");

    AST_HIZ_CONVERT: assert property (
        s.phase == phase_convert && $past(s.phase) == phase_convert
        && $past(cnv_s | sdi_s) |-> serial_result_oe_n_out)
        else $error("output driven during conversion");

    AST_BUSY_LOW: assert property (
        conv_done && s.phase == phase_convert && s.select_mode && selected
        && !cnv_rise |=> !serial_result_oe_n_out && !serial_result_out
        && power_down_out)
        else $error("busy low not driven at completion");

    AST_LEAD_THEN_MSB: assert property (
        s.reading && s.lead && s.select_mode && sck_fall && selected
        && !cnv_rise |=> !serial_result_oe_n_out
        && serial_result_out == $past(s.shreg[WIDTH-1]))
        else $error("msb not shown after the start bit");

    AST_END_BUSY: assert property (
        s.reading && s.select_mode && s.busy_en && sck_fall && selected
        && s.rd_cnt == READ_END_BUSY - RD_CNT_WIDTH'(1) && !cnv_rise
        |=> !s.reading
        && (serial_result_oe_n_out || !$past(cnv_s | sdi_s)))
        else $error("busy readout not floating after fifteenth fall");

    AST_BOTH_LOW: assert property (
        !cnv_s && !sdi_s && !next_s.reading
        |=> !serial_result_oe_n_out && !serial_result_out)
        else $error("output not driven low with both lines low");

    AST_MSB_SELECT: assert property (
        !s.reading && next_s.reading && s.phase == phase_acquire
        && s.select_mode |=> !serial_result_oe_n_out
        && serial_result_out == $past(s.shreg[WIDTH-1]))
        else $error("msb not shown on selection");

    AST_END_PLAIN: assert property (
        s.reading && s.select_mode && !s.busy_en && sck_fall && !cnv_rise
        && s.rd_cnt == READ_END_PLAIN - RD_CNT_WIDTH'(1)
        |=> !s.reading ##1 (serial_result_oe_n_out || !$past(selected)))
        else $error("plain readout not ended at fourteenth fall");

    AST_DESELECT: assert property (
        s.reading && s.select_mode && !selected && !cnv_rise
        |=> !s.reading ##1 serial_result_oe_n_out)
        else $error("output not floating after deselection");

    AST_MSB_CHAIN: assert property (
        conv_done && s.phase == phase_convert && !s.select_mode
        && !s.busy_en && !cnv_rise |=> !serial_result_oe_n_out
        && serial_result_out == $past(result_in[WIDTH-1]))
        else $error("chain msb not shown at completion");

    AST_CHAIN_SHIFT: assert property (
        s.reading && !s.select_mode && !s.lead && sck_fall && cnv_s
        && !cnv_rise |=> s.shreg == {$past(s.shreg[WIDTH-2:0]), $past(sdi_s)})
        else $error("chain register did not shift in chain select");

    COV_SELECT_BUSY: cover property (
        conv_done && s.select_mode && selected);
    COV_SELECT_PLAIN_END: cover property (
        s.reading && s.select_mode && !s.busy_en && sck_fall
        && s.rd_cnt == READ_END_PLAIN - RD_CNT_WIDTH'(1));
    COV_CHAIN_READ: cover property (
        s.reading && !s.select_mode && sck_fall ##1 s.reading);

endmodule

//--- bench/sar_host_model.sv
`timescale 1ns/1ps
module sar_host_model (
    input  wire logic clk_in,
    input  wire logic line_in,
    output logic      conversion_trigger_out,
    output logic      chain_select_input_out,
    output logic      serial_clock_out
);
    logic [27:0] got;

    initial begin
        conversion_trigger_out = 1'b0;
        chain_select_input_out = 1'b1;
        serial_clock_out       = 1'b0;
        got                    = '0;
    end

    // trigger moves only between frames and select also within them; set_pins moves trigger, select and clock on a system clock edge
    task automatic set_pins(input logic t, input logic s, input logic k);
        @(posedge clk_in);
        conversion_trigger_out <= t;
        chain_select_input_out <= s;
        serial_clock_out       <= k;
    endtask

    // link clock runs only inside a frame; capture on the rising edge
    task automatic frame(input int n, input logic [27:0] feed);
        got = '0;
        for (int i = n - 1; i >= 0; i--) begin
            #62.5 serial_clock_out = 1'b1;
            got = {got[26:0], line_in};
            chain_select_input_out = feed[i];
            #62.5 serial_clock_out = 1'b0;
        end
        #62.5;
    endtask
endmodule

//--- bench/test_sar_adc_serial_readout.sv
`timescale 1ns/1ps
module test_sar_adc_serial_readout
    import sar_readout_pkg::*;
();
    localparam logic [13:0] RES = 14'h2a5c;
    localparam logic [13:0] PAT = 14'h1b37;
    logic                  clk_in = 1'b0;
    logic                  rst_n_in;
    logic [13:0]           result_in;
    logic [ADDR_WIDTH-1:0] addr_in;
    logic [DATA_WIDTH-1:0] wr_data_in;
    logic                  wr_en_in;
    logic                  rd_en_in;
    logic [DATA_WIDTH-1:0] rd_data_out;
    logic                  serial_result_out;
    logic                  serial_result_oe_n_out;
    logic                  power_down_out;
    logic                  trig;
    logic                  csel;
    logic                  sclk;
    logic                  pull_up;
    logic                  last_bit = 1'b0;
    logic                  line;
    logic [DATA_WIDTH-1:0] rv;
    int                    n_fail = 0;
    int                    compares = 0;

    always #4 clk_in = ~clk_in;

    // released line: pull-up in the select-mode busy tests, else an inverted stale level
    always @(posedge clk_in)
        if (!serial_result_oe_n_out) last_bit <= serial_result_out;
    assign line = serial_result_oe_n_out ? (pull_up | ~last_bit)
                                         : serial_result_out;

    sar_adc_serial_readout i_sar_adc_serial_readout (
        .clk_in                 (clk_in),
        .rst_n_in               (rst_n_in),
        .conversion_trigger_in  (trig),
        .chain_select_input_in  (csel),
        .serial_clock_in        (sclk),
        .result_in              (result_in),
        .addr_in                (addr_in),
        .wr_data_in             (wr_data_in),
        .wr_en_in               (wr_en_in),
        .rd_en_in               (rd_en_in),
        .rd_data_out            (rd_data_out),
        .serial_result_out      (serial_result_out),
        .serial_result_oe_n_out (serial_result_oe_n_out),
        .power_down_out         (power_down_out)
    );

    sar_host_model i_sar_host_model (
        .clk_in                 (clk_in),
        .line_in                (line),
        .conversion_trigger_out (trig),
        .chain_select_input_out (csel),
        .serial_clock_out       (sclk)
    );

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_en_in   <= 1'b1;
        addr_in    <= a;
        wr_data_in <= d;
        @(posedge clk_in);
        wr_en_in   <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd_en_in <= 1'b1;
        addr_in  <= a;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 d = rd_data_out;
    endtask

    task automatic wait_oe(input logic v);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_in);
            #1;
            if (serial_result_oe_n_out === v) break;
        end
        chk("oe_n wait", serial_result_oe_n_out, v);
    endtask

    task automatic settle_oe(input logic v);
        repeat (6) @(posedge clk_in);
        #1 chk("oe_n", serial_result_oe_n_out, v);
    endtask

    task automatic report_and_stop();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #300000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        rst_n_in   = 1'b0;
        result_in  = RES;
        addr_in    = '0;
        wr_data_in = '0;
        wr_en_in   = 1'b0;
        rd_en_in   = 1'b0;
        pull_up    = 1'b1;
        repeat (10) @(posedge clk_in);
        #1 chk("oe_n reset", serial_result_oe_n_out, 1'b1);
        chk("pd reset", power_down_out, 1'b1);
        chk("rd reset", rd_data_out, '0);
        rst_n_in <= 1'b1;
        rd(REG_CONFIG, rv);
        chk("config reset", rv, 32'(CONFIG_RESET));
        wr(REG_CONFIG, 32'h14);
        rd(4'hc, rv);
        chk("unmapped", rv, '0);
        // both pins low: driven low while idle
        i_sar_host_model.set_pins(1'b0, 1'b0, 1'b0);
        settle_oe(1'b0);
        chk("drive low", serial_result_out, 1'b0);
        // 3-wire with busy
        i_sar_host_model.set_pins(1'b0, 1'b1, 1'b0);
        i_sar_host_model.set_pins(1'b1, 1'b1, 1'b0);
        settle_oe(1'b1);
        chk("pd conv", power_down_out, 1'b0);
        i_sar_host_model.set_pins(1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clk_in);
        #1 chk("float conv", serial_result_oe_n_out, 1'b1);
        wait_oe(1'b0);
        chk("busy low", serial_result_out, 1'b0);
        chk("pd", power_down_out, 1'b1);
        i_sar_host_model.frame(15, '1);
        chk("3w bits", i_sar_host_model.got[14:0], {1'b0, RES});
        settle_oe(1'b1);
        rd(REG_RESULT, rv);
        chk("result reg", rv, 32'(RES));
        @(posedge clk_in);
        #1 chk("rd idle", rd_data_out, '0);
        rd(REG_STATUS, rv);
        chk("status sel busy", rv[1:0], 2'b11);
        // 4-wire without busy
        pull_up = 1'b0;
        i_sar_host_model.set_pins(1'b1, 1'b1, 1'b0);
        repeat (40) @(posedge clk_in);
        #1 chk("no busy", serial_result_oe_n_out, 1'b1);
        i_sar_host_model.set_pins(1'b1, 1'b0, 1'b0);
        settle_oe(1'b0);
        i_sar_host_model.frame(14, '0);
        chk("4w bits", i_sar_host_model.got[13:0], RES);
        settle_oe(1'b1);
        // 4-wire with busy, cut short by deselect
        pull_up = 1'b1;
        i_sar_host_model.set_pins(1'b0, 1'b1, 1'b0);
        i_sar_host_model.set_pins(1'b1, 1'b1, 1'b0);
        i_sar_host_model.set_pins(1'b1, 1'b0, 1'b0);
        wait_oe(1'b0);
        chk("4w busy low", serial_result_out, 1'b0);
        i_sar_host_model.frame(5, '0);
        chk("4w part", i_sar_host_model.got[4:0], {1'b0, RES[13:10]});
        i_sar_host_model.set_pins(1'b1, 1'b1, 1'b0);
        settle_oe(1'b1);
        // chain without busy
        pull_up = 1'b0;
        i_sar_host_model.set_pins(1'b0, 1'b0, 1'b0);
        i_sar_host_model.set_pins(1'b1, 1'b0, 1'b0);
        repeat (40) @(posedge clk_in);
        #1 chk("chain msb", serial_result_out, RES[13]);
        chk("chain oe", serial_result_oe_n_out, 1'b0);
        rd(REG_STATUS, rv);
        chk("chain mode", rv[1:0], 2'b00);
        i_sar_host_model.frame(28, {PAT, 14'h0});
        chk("chain bits", i_sar_host_model.got, {RES, PAT});
        // chain with clock high at trigger rise
        i_sar_host_model.set_pins(1'b0, 1'b0, 1'b1);
        i_sar_host_model.set_pins(1'b1, 1'b0, 1'b1);
        repeat (6) @(posedge clk_in);
        rd(REG_STATUS, rv);
        chk("chain busy", rv[1:0], 2'b10);
        i_sar_host_model.set_pins(1'b1, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule
